//--- token_defines.svh
// Constants for the token semaphore port controller.
`ifndef TOKEN_DEFINES_SVH
`define TOKEN_DEFINES_SVH
`define FLAG_COUNT        8
`define INDEX_WIDTH       3
`define ADDR_WIDTH        19
`define DATA_WIDTH        36
`define LANE_COUNT        4
`define SETUP_CYCLES      4'h1
`define STROBE_CYCLES     4'h2
`define RECOVER_CYCLES    4'h1
`define OP_CLAIM          2'h0
`define OP_RELEASE        2'h1
`define OP_POLL           2'h2
`endif

//--- token_pkg.sv
// Types for the token semaphore port controller.
package token_pkg;
	typedef enum logic [2:0] {
		IDLE_S     = 3'h0,
		SETUP_S    = 3'h1,
		STROBE_S   = 3'h3,
		RECOVER_S  = 3'h2,
		DONE_S     = 3'h6
	} phase_type;
endpackage : token_pkg

//--- token_claim_mem.sv
// Small memory recording which flags this side believes it holds.
`timescale 1ns/1ps
`include "token_defines.svh"
module token_claim_mem (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// Write side
	input  wire logic                     wr_en,
	input  wire logic [`INDEX_WIDTH-1:0]  wr_index,
	input  wire logic                     wr_held,
	// Read side
	input  wire logic [`INDEX_WIDTH-1:0]  rd_index,
	output logic                          rd_held
);
	logic [`FLAG_COUNT-1:0] held_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			held_q <= '0;
		end else if (wr_en) begin
			held_q[wr_index] <= wr_held;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_held <= 1'b0;
		end else begin
			rd_held <= held_q[rd_index];
		end
	end
endmodule : token_claim_mem

//--- token_port_ctrl.sv
// Port-side controller that claims, polls and releases semaphore tokens.
`timescale 1ns/1ps
`include "token_defines.svh"
module token_port_ctrl
	import token_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// Command
	input  wire logic                     cmd_valid,
	input  wire logic [1:0]               cmd_op,
	input  wire logic [`INDEX_WIDTH-1:0]  cmd_index,
	output logic                          cmd_ready,
	output logic                          init_busy,
	output logic                          rsp_valid,
	output logic                          rsp_granted,
	output logic                          rsp_held,
	// Device port pins
	output logic                          token_space_select_n,
	output logic                          chip_enable_low_active,
	output logic                          chip_enable_high_active,
	output logic                          write_n,
	output logic                          output_enable_n,
	output logic [`LANE_COUNT-1:0]        byte_lane_enable_n,
	output logic [`ADDR_WIDTH-1:0]        addr_out,
	output logic [`DATA_WIDTH-1:0]        data_out,
	output logic [`DATA_WIDTH-1:0]        data_oe,
	input  wire logic [`DATA_WIDTH-1:0]   data_in
);
	// ==========================================================
	// Sequencer state
	phase_type                 phase_q;
	logic [3:0]                cnt_q;
	logic                      is_write_q;
	logic                      value_q;
	logic [1:0]                op_q;
	logic [`INDEX_WIDTH-1:0]   index_q;
	logic                      init_q;
	logic                      init_side_done_q;
	logic                      mem_wr;
	logic                      flag_read;
	logic                      unused_held;

	// flag on data
	// Every bit carries the flag; bit zero is taken as representative.
	assign flag_read = data_in[0];

	function automatic logic [3:0] phase_len(input phase_type p);
		unique case (p)
			SETUP_S:   phase_len = `SETUP_CYCLES;
			STROBE_S:  phase_len = `STROBE_CYCLES;
			RECOVER_S: phase_len = `RECOVER_CYCLES;
			default:   phase_len = 4'h1;
		endcase
	endfunction : phase_len

	// ==========================================================
	// Phase sequencing
	// write before read
	// A claim is a write of zero followed by a read-back; a poll is a read only.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_q    <= IDLE_S;
			cnt_q      <= 4'h0;
			is_write_q <= 1'b0;
			value_q    <= 1'b1;
			op_q       <= `OP_POLL;
			index_q    <= '0;
			init_q     <= 1'b1;
			init_side_done_q <= 1'b0;
		end else begin
			unique case (phase_q)
				IDLE_S: begin
					if (init_q) begin
						phase_q    <= SETUP_S;
						cnt_q      <= `SETUP_CYCLES;
						is_write_q <= 1'b1;
						value_q    <= 1'b1;
						op_q       <= `OP_RELEASE;
					end else if (cmd_valid && !rsp_valid) begin
						// The requester drops its request only after seeing the
						// response, so a request still standing then is the old one.
						phase_q    <= SETUP_S;
						cnt_q      <= `SETUP_CYCLES;
						op_q       <= cmd_op;
						index_q    <= cmd_index;
						is_write_q <= (cmd_op != `OP_POLL);
						value_q    <= (cmd_op == `OP_RELEASE);
					end
				end
				SETUP_S, STROBE_S, RECOVER_S: begin
					if (cnt_q > 4'h1) begin
						cnt_q <= cnt_q - 4'h1;
					end else if (phase_q == SETUP_S) begin
						phase_q <= STROBE_S;
						cnt_q   <= `STROBE_CYCLES;
					end else if (phase_q == STROBE_S) begin
						phase_q <= RECOVER_S;
						cnt_q   <= `RECOVER_CYCLES;
					end else if (is_write_q && op_q == `OP_CLAIM) begin
						// Read back the claim so the result is confirmed.
						phase_q    <= SETUP_S;
						cnt_q      <= `SETUP_CYCLES;
						is_write_q <= 1'b0;
					end else begin
						phase_q <= DONE_S;
					end
				end
				DONE_S: begin
					phase_q <= IDLE_S;
					if (init_q) begin
						index_q <= index_q + 3'h1;
						if (index_q == 3'h7) begin
							init_q <= 1'b0;
							init_side_done_q <= 1'b1;
						end
					end
				end
				default: phase_q <= IDLE_S;
			endcase
		end
	end

	// ==========================================================
	// Pin drive
	// static memory strobes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			token_space_select_n    <= 1'b1;
			chip_enable_low_active  <= 1'b1;
			chip_enable_high_active <= 1'b0;
			write_n                 <= 1'b1;
			output_enable_n         <= 1'b1;
			byte_lane_enable_n      <= '1;
			addr_out                <= '0;
			data_out                <= '0;
			data_oe                 <= '0;
		end else begin
			chip_enable_low_active  <= 1'b1;
			chip_enable_high_active <= 1'b0;
			addr_out <= {{(`ADDR_WIDTH-`INDEX_WIDTH){1'b0}}, index_q};
			data_out <= {{(`DATA_WIDTH-1){1'b0}}, value_q};
			if (phase_q == SETUP_S || phase_q == STROBE_S) begin
				token_space_select_n <= 1'b0;
				byte_lane_enable_n   <= '0;
				output_enable_n      <= is_write_q;
				write_n              <= !(is_write_q && phase_q == STROBE_S);
				data_oe              <= {`DATA_WIDTH{is_write_q}};
			end else begin
				token_space_select_n <= 1'b1;
				byte_lane_enable_n   <= '1;
				output_enable_n      <= 1'b1;
				write_n              <= 1'b1;
				data_oe              <= '0;
			end
		end
	end

	// ==========================================================
	// Result
	// sample at strobe end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsp_valid   <= 1'b0;
			rsp_granted <= 1'b0;
			rsp_held    <= 1'b0;
			cmd_ready   <= 1'b0;
			init_busy   <= 1'b1;
		end else begin
			cmd_ready <= (phase_q == IDLE_S) && !init_q && !cmd_valid;
			init_busy <= init_q;
			rsp_valid <= (phase_q == DONE_S) && !init_q;
			if (phase_q == STROBE_S && cnt_q == 4'h1 && !is_write_q) begin
				rsp_granted <= !flag_read;
				rsp_held    <= !flag_read;
			end else if (phase_q == STROBE_S && cnt_q == 4'h1 && op_q == `OP_RELEASE) begin
				rsp_granted <= 1'b0;
				rsp_held    <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Ownership record
	// owner only modifies
	assign mem_wr = (phase_q == DONE_S);
	token_claim_mem u_claim (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.wr_en    (mem_wr),
		.wr_index (index_q),
		.wr_held  (rsp_held),
		.rd_index (cmd_index),
		.rd_held  (unused_held)
	);
	logic unused_ok;
	assign unused_ok = unused_held & init_side_done_q;
endmodule : token_port_ctrl

//--- token_chk.sv
// Pin checker for the token port controller.
`timescale 1ns/1ps
`include "token_defines.svh"
module token_chk (
	// Clock, reset and status
	input wire logic                   clk,
	input wire logic                   sys_rst,
	input wire logic                   init_busy,
	input wire logic                   rsp_valid,
	// Device pins
	input wire logic                   token_space_select_n,
	input wire logic                   chip_enable_low_active,
	input wire logic                   chip_enable_high_active,
	input wire logic                   write_n,
	input wire logic                   output_enable_n,
	input wire logic [`LANE_COUNT-1:0] byte_lane_enable_n,
	input wire logic [`ADDR_WIDTH-1:0] addr_out,
	input wire logic [`DATA_WIDTH-1:0] data_out,
	input wire logic [`DATA_WIDTH-1:0] data_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Pin relations
	sequence s_wr0; !write_n && !data_out[0]; endsequence
	sequence s_rd; !output_enable_n && write_n; endsequence
	property p_order; s_wr0 |-> ##[1:6] s_rd; endproperty
	property p_array; chip_enable_low_active && !chip_enable_high_active; endproperty
	property p_rdsel; !output_enable_n |-> !token_space_select_n && byte_lane_enable_n == 0;
	endproperty
	property p_wrsel; !write_n |-> !token_space_select_n && data_oe[0]; endproperty
	property p_noclash; !output_enable_n |-> data_oe == 0 && write_n; endproperty
	property p_addr; !token_space_select_n && $past(!token_space_select_n) |-> $stable(addr_out);
	endproperty
	property p_pulse; rsp_valid |=> !rsp_valid; endproperty
	property p_init; init_busy && !write_n |-> data_out[0]; endproperty
	a_order: assert property (p_order) else $error("claim write not followed by read");
	a_array: assert property (p_array) else $error("array enables not off");
	a_rdsel: assert property (p_rdsel) else $error("read strobes incomplete");
	a_wrsel: assert property (p_wrsel) else $error("write outside token space");
	a_noclash: assert property (p_noclash) else $error("data driven during read");
	a_addr: assert property (p_addr) else $error("address moved in access");
	a_pulse: assert property (p_pulse) else $error("response longer than one cycle");
	a_init: assert property (p_init) else $error("init wrote zero");
endmodule : token_chk

//--- token_dev.sv
// Behavioural two-sided token flag device.
`timescale 1ns/1ps
module token_dev (
	// Near side pins
	input wire logic        clk,
	input wire logic        token_space_select_n,
	input wire logic        write_n,
	input wire logic        output_enable_n,
	input wire logic [18:0] addr_out,
	input wire logic [35:0] data_out,
	output logic     [35:0] data_in,
	// Far side requests
	input wire logic        far_wr,
	input wire logic [2:0]  far_idx,
	input wire logic        far_val
);
	// ==========================================
	// Latches and flags
	// both sides' eight request latches start unknown
	logic [7:0] req_a = 'x, req_b = 'x, own_a = 0, own_b = 0;
	logic cap = 0, rd_on = 0, rd;
	logic [35:0] last = 0;
	assign rd = !token_space_select_n && !output_enable_n;
	assign data_in = rd ? {36{rd_on ? cap : !own_a[addr_out[2:0]]}} : ~last;
	always @(posedge clk) begin
		last <= data_in;
		if (rd && !rd_on) cap = !own_a[addr_out[2:0]];
		rd_on = rd;
		if (!token_space_select_n && !write_n) req_a[addr_out[2:0]] = data_out[0];
		if (far_wr) req_b[far_idx] = far_val;
		for (int i = 0; i < 8; i++) begin
			if (own_a[i] && req_a[i] === 1'b1) own_a[i] = 0;
			if (own_b[i] && req_b[i] === 1'b1) own_b[i] = 0;
			if (!own_a[i] && !own_b[i]) begin
				own_a[i] = req_a[i] === 1'b0;
				own_b[i] = !own_a[i] && req_b[i] === 1'b0;
			end
		end
	end
endmodule : token_dev

//--- testbench.sv
// Random claim, poll and release traffic against a flag model.
`timescale 1ns/1ps
`include "token_defines.svh"
module testbench;
	logic clk = 0, sys_rst = 1, cmd_valid = 0, far_wr = 0, far_val = 0;
	logic [1:0] cmd_op = 0;
	logic [2:0] cmd_index = 0, far_idx = 0;
	logic cmd_ready, init_busy, rsp_valid, rsp_granted, rsp_held, token_space_select_n;
	logic chip_enable_low_active, chip_enable_high_active, write_n, output_enable_n;
	logic [3:0] byte_lane_enable_n;
	logic [18:0] addr_out;
	logic [35:0] data_out, data_oe, data_in;
	int fail_count = 0, comparisons = 0, cycles = 0, seed = 10;
	int ra[8] = '{default: 1}, rb[8] = '{default: 1}, own[8] = '{default: 0};
	token_port_ctrl DUT (.*);
	token_dev u_dev (.*);
	always #20 clk = ~clk;
	// ==========================================
	// Helpers
	task end_sim();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			fail_count++;
			end_sim();
		end
	end
	function int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task check(input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t flag response differs", $time);
		end
	endtask : check
	// Earlier latch owns the flag; a tie goes to this side.
	task resolve();
		for (int i = 0; i < 8; i++) begin
			if (own[i] == 1 && ra[i] == 1) own[i] = 0;
			if (own[i] == 2 && rb[i] == 1) own[i] = 0;
			if (own[i] == 0) own[i] = ra[i] == 0 ? 1 : rb[i] == 0 ? 2 : 0;
		end
	endtask : resolve
	task far(input int i, input int v);
		@(posedge clk);
		far_idx <= i[2:0];
		far_val <= v[0];
		far_wr <= 1;
		@(posedge clk);
		far_wr <= 0;
		rb[i] = v;
		resolve();
	endtask : far
	task cmd(input int op, input int i);
		int n;
		@(posedge clk);
		cmd_op <= op[1:0];
		cmd_index <= i[2:0];
		cmd_valid <= 1;
		n = 0;
		do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 100);
		cmd_valid <= 0;
		check(rsp_valid, 1'b1);
		// A poll only reads, so it leaves this side's request latch alone.
		if (op == 0) ra[i] = 0;
		if (op == 1) ra[i] = 1;
		resolve();
		if (op == 1) check(rsp_held, 1'b0);
		if (op != 1) check(rsp_held, own[i] == 1);
		if (op == 0) check(rsp_granted, own[i] == 1);
	endtask : cmd
	// ==========================================
	// Main sequence
	initial begin
		int n;
		repeat (8) @(posedge clk);
		sys_rst <= 0;
		for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(posedge clk);
		check(init_busy, 1'b0);
		check(cmd_ready, 1'b1);
		for (n = 0; n < 8; n++) far(n, 1);
		for (n = 0; n < 8; n++) cmd(2, n);
		for (n = 0; n < 80; n++) begin
			if (rnd() & 1) far(rnd() & 7, rnd() & 1);
			cmd((rnd() & 3) % 3, rnd() & 7);
		end
		end_sim();
	end
endmodule : testbench
bind token_port_ctrl token_chk u_chk (.*);
